// >>> shared/adcsc_regs.svh
// Constants for the ADC setup and pair configuration block
`ifndef ADCSC_REGS_SVH
`define ADCSC_REGS_SVH

`define ADCSC_SET_SEL_MSB      7
`define ADCSC_SET_SEL_LSB      6
`define ADCSC_SET_SEL_VAL      2'h1
`define ADCSC_SET_CLK_MSB      5
`define ADCSC_SET_CLK_LSB      4
`define ADCSC_SET_REF_MSB      3
`define ADCSC_SET_REF_LSB      2
`define ADCSC_SET_PSEL_MSB     1
`define ADCSC_SET_PSEL_LSB     0
`define ADCSC_SETUP_RST        8'h20
`define ADCSC_PAIR_RST         8'h00
`define ADCSC_CONV_RST         8'h00
`define ADCSC_FRAME_LEAD       4'h0
`define ADCSC_TEMP_K_OFFSET    12'h889
`define ADCSC_REF_WAKE_NS      65000
`define ADCSC_CLK_PERIOD_NS    4
`define ADCSC_REF_WAKE_CYC     ((`ADCSC_REF_WAKE_NS + `ADCSC_CLK_PERIOD_NS - 1) / `ADCSC_CLK_PERIOD_NS)
`define ADCSC_SCLK_CONV_MAX_KHZ 4800

`endif

// >>> shared/adcsc_pkg.sv
// Types shared by the ADC setup and pair configuration block
package adcsc_pkg;
  typedef enum logic [1:0] {CK_INT_AUTO, CK_INT_EXTACQ, CK_INT_SERIAL, CK_SCLK} adcsc_clk_mode_t;
  typedef enum logic [1:0] {RF_INT_AUTO, RF_EXT_SE, RF_INT_ON, RF_EXT_DIFF} adcsc_ref_mode_t;
  typedef enum logic [2:0] {CMD_NONE, CMD_RESET, CMD_AVG, CMD_SETUP, CMD_CONV} adcsc_cmd_t;
  typedef enum logic [1:0] {DEC_CMD, DEC_UNI, DEC_BI} adcsc_dec_state_t;
endpackage

// >>> shared/adcsc_link_if.sv
// Carrier between the system-clock core and the serial-clock link logic
`timescale 1ns/1ps
interface adcsc_link_if;
  logic [8:0]  rx_word;
  logic        rx_tgl;
  logic [15:0] tx_word;
  logic        tx_req;
  logic        tx_ack;
  modport sys (input rx_word, input rx_tgl, input tx_ack, output tx_word, output tx_req);
  modport lnk (output rx_word, output rx_tgl, output tx_ack, input tx_word, input tx_req);
endinterface

// >>> verilog/adcsc_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module adcsc_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("adcsc_sync width must be at least one");
  end

  // The first stage feeds nothing but the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// >>> verilog/adcsc_link.sv
// Serial-clock side: byte receiver and 16-bit frame transmitter
`timescale 1ns/1ps
module adcsc_link (
  input  wire logic   sclk_i,
  input  wire logic   rst_n_i,
  input  wire logic   cs_n_i,
  input  wire logic   din_i,
  output logic        dout_o,
  adcsc_link_if.lnk   lnk
);
  logic [2:0]  bit_cnt_q;
  logic [6:0]  sh_q;
  logic        first_q;
  logic        req_s;
  logic [15:0] frame_q;
  logic [3:0]  out_idx_q;

  adcsc_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .clk_i   (sclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (lnk.tx_req),
    .q_o     (req_s)
  );

  // Select high reframes the byte counter; the clock may be still then
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_q <= 3'h0;
      sh_q      <= 7'h00;
      first_q   <= 1'b1;
    end else begin
      sh_q      <= {sh_q[5:0], din_i};
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7) begin
        first_q <= 1'b0;
      end
    end
  end

  // Byte and its first-of-frame flag stay put for eight serial clocks
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lnk.rx_word <= 9'h000;
      lnk.rx_tgl  <= 1'b0;
    end else if (!cs_n_i && bit_cnt_q == 3'h7) begin
      lnk.rx_word <= {first_q, sh_q, din_i};
      lnk.rx_tgl  <= ~lnk.rx_tgl;
    end
  end

  // A pending word is taken at a frame's first rising edge; the request needs two serial clocks
  // to sync, so a word raised while the clock stands still goes out one frame later
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_q    <= 16'h0000;
      lnk.tx_ack <= 1'b0;
    end else if (!cs_n_i && first_q && bit_cnt_q == 3'h0) begin
      if (req_s != lnk.tx_ack) begin
        frame_q    <= lnk.tx_word;
        lnk.tx_ack <= req_s;
      end else begin
        frame_q <= 16'h0000;
      end
    end
  end

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_idx_q <= 4'h0;
      dout_o    <= 1'b0;
    end else begin
      dout_o    <= frame_q[4'hf - out_idx_q];
      out_idx_q <= out_idx_q + 4'h1;
    end
  end
endmodule

// >>> verilog/adcsc_top.sv
// ADC setup decoding, pair configuration, launch control and result framing
`timescale 1ns/1ps
`include "adcsc_regs.svh"
module adcsc_top #(
  parameter int unsigned REF_WAKE_CYCLES = `ADCSC_REF_WAKE_CYC,
  parameter logic [11:0] TEMP_K_OFFSET   = `ADCSC_TEMP_K_OFFSET
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       sclk_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       din_i,
  output logic                            dout_o,
  input  wire logic                       conv_start_n_i,
  input  wire logic                       scan_done_i,
  input  wire logic                       result_valid_i,
  input  wire logic [9:0]                 result_code_i,
  input  wire logic [1:0]                 result_sub_i,
  input  wire logic                       result_diff_i,
  input  wire logic [2:0]                 result_pair_i,
  input  wire logic                       temp_valid_i,
  input  wire logic [11:0]                temp_first_i,
  input  wire logic [11:0]                temp_second_i,
  output logic                            result_ready_o,
  output adcsc_pkg::adcsc_clk_mode_t      clk_mode_o,
  output adcsc_pkg::adcsc_ref_mode_t      vref_mode_o,
  output logic [7:0]                      pair_uni_o,
  output logic [7:0]                      pair_bi_o,
  output logic [7:0]                      pair_diff_o,
  output logic [7:0]                      pair_bipolar_o,
  output logic [7:0]                      conv_cmd_o,
  output logic                            conv_go_o,
  output logic                            acq_hold_o,
  output logic                            int_conv_clk_o,
  output logic                            sclk_conv_clk_o,
  output logic                            start_pin_analog_o,
  output logic                            refneg_analog_o,
  output logic                            ref_ext_o,
  output logic                            ref_ext_diff_o,
  output logic                            vref_on_o,
  output logic                            core_awake_o
);
  import adcsc_pkg::*;

  localparam int WCW = $clog2(REF_WAKE_CYCLES + 1);

  if (REF_WAKE_CYCLES < 1) begin : g_chk_wake
    $error("REF_WAKE_CYCLES must be at least one");
  end

  adcsc_link_if lif ();

  logic            rx_tgl_s;
  logic            rx_seen_q;
  logic            ack_s;
  logic            conv_start_s;
  logic            conv_start_d_q;
  logic            byte_stb;
  logic            byte_first;
  logic [7:0]      byte_val;
  adcsc_cmd_t      byte_cls;
  logic            data_stb;
  logic            cmd_stb;
  logic            setup_wr;
  logic            conv_wr;
  adcsc_dec_state_t dec_q;
  logic [7:0]      setup_q;
  logic [7:0]      uni_q;
  logic [7:0]      bi_q;
  logic [7:0]      conv_q;
  logic            launch;
  logic            need_wake;
  logic            cnv_rise;
  logic            waking_q;
  logic [WCW-1:0]  wake_cnt_q;
  logic            conv_go_q;
  logic            vref_on_q;
  logic            awake_q;
  logic [15:0]     tx_word_q;
  logic            tx_req_q;
  logic            tx_pend;
  logic            pair_bip;
  logic [9:0]      code_fmt;
  logic [13:0]     temp_diff;

  // Position of the first one among the upper bits picks the target
  function automatic adcsc_cmd_t cmd_class(input logic [7:0] b);
    if (b[7]) begin
      return CMD_CONV;
    end else if (b[6]) begin
      return CMD_SETUP;
    end else if (b[5]) begin
      return CMD_AVG;
    end else if (b[4]) begin
      return CMD_RESET;
    end else begin
      return CMD_NONE;
    end
  endfunction

  // Bit 7 holds pair 0/1, bit 0 holds pair 14/15
  function automatic logic pair_flag(input logic [7:0] r, input logic [2:0] idx);
    return r[3'h7 - idx];
  endfunction

  adcsc_link u_link (
    .sclk_i  (sclk_i),
    .rst_n_i (rst_n_i),
    .cs_n_i  (cs_n_i),
    .din_i   (din_i),
    .dout_o  (dout_o),
    .lnk     (lif.lnk)
  );

  adcsc_sync #(.W(1), .RST_VAL(1'b0)) u_rx_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .d_i     (lif.rx_tgl),
    .q_o     (rx_tgl_s)
  );

  adcsc_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .d_i     (lif.tx_ack),
    .q_o     (ack_s)
  );

  adcsc_sync #(.W(1), .RST_VAL(1'b1)) u_cnv_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .d_i     (conv_start_n_i),
    .q_o     (conv_start_s)
  );

  // Byte word is stable for eight serial clocks, far longer than the sync delay
  assign byte_stb   = rx_tgl_s != rx_seen_q;
  assign byte_first = lif.rx_word[8];
  assign byte_val   = lif.rx_word[7:0];
  assign byte_cls   = cmd_class(byte_val);
  assign data_stb   = byte_stb && !byte_first && dec_q != DEC_CMD;
  assign cmd_stb    = byte_stb && !data_stb;
  assign setup_wr   = cmd_stb && byte_cls == CMD_SETUP;
  assign conv_wr    = cmd_stb && byte_cls == CMD_CONV;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_seen_q <= 1'b0;
      conv_start_d_q <= 1'b1;
    end else begin
      rx_seen_q <= rx_tgl_s;
      conv_start_d_q <= conv_start_s;
    end
  end

  // Decoder: a pair-select setup byte arms one data byte in the same frame
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_q <= DEC_CMD;
    end else if (byte_stb) begin
      case (dec_q)
        DEC_CMD, DEC_UNI, DEC_BI: begin
          if (setup_wr) begin
            case (byte_val[`ADCSC_SET_PSEL_MSB:`ADCSC_SET_PSEL_LSB])
              2'h2:    dec_q <= DEC_UNI;
              2'h3:    dec_q <= DEC_BI;
              default: dec_q <= DEC_CMD;
            endcase
          end else begin
            dec_q <= DEC_CMD;
          end
        end
        default: dec_q <= DEC_CMD;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setup_q <= `ADCSC_SETUP_RST;
    end else if (setup_wr) begin
      setup_q <= byte_val;
    end
  end

  // Pair registers change only on the byte right after a selecting setup byte
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uni_q <= `ADCSC_PAIR_RST;
      bi_q  <= `ADCSC_PAIR_RST;
    end else if (data_stb) begin
      if (dec_q == DEC_UNI) begin
        uni_q <= byte_val;
      end else if (dec_q == DEC_BI) begin
        bi_q <= byte_val;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_q <= `ADCSC_CONV_RST;
    end else if (conv_wr) begin
      conv_q <= byte_val;
    end
  end

  assign clk_mode_o  = adcsc_clk_mode_t'(setup_q[`ADCSC_SET_CLK_MSB:`ADCSC_SET_CLK_LSB]);
  assign vref_mode_o = adcsc_ref_mode_t'(setup_q[`ADCSC_SET_REF_MSB:`ADCSC_SET_REF_LSB]);
  assign pair_uni_o  = uni_q;
  assign pair_bi_o   = bi_q;
  assign conv_cmd_o  = conv_q;

  for (genvar i = 0; i < 8; i++) begin : g_pair
    assign pair_diff_o[i]    = uni_q[i] | bi_q[i];
    assign pair_bipolar_o[i] = bi_q[i] & ~uni_q[i];
  end

  // Clock-mode decode
  assign int_conv_clk_o  = clk_mode_o != CK_SCLK;
  assign acq_hold_o      = clk_mode_o == CK_INT_EXTACQ && !conv_start_s;
  assign sclk_conv_clk_o = clk_mode_o == CK_SCLK;
  assign start_pin_analog_o = clk_mode_o == CK_INT_SERIAL || clk_mode_o == CK_SCLK;

  // Reference-mode decode
  assign refneg_analog_o = vref_mode_o != RF_EXT_DIFF;
  assign ref_ext_o       = vref_mode_o == RF_EXT_SE || vref_mode_o == RF_EXT_DIFF;
  assign ref_ext_diff_o  = vref_mode_o == RF_EXT_DIFF;

  // The pin launches on its rising edge, ending the low acquisition phase
  assign cnv_rise  = conv_start_s && !conv_start_d_q;
  assign launch    = (clk_mode_o == CK_INT_AUTO || clk_mode_o == CK_INT_EXTACQ) ? cnv_rise : conv_wr;
  assign need_wake = launch && !waking_q && vref_mode_o == RF_INT_AUTO && !vref_on_q;

  // A launch while the reference is still waking is dropped; the host must pace requests
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      waking_q   <= 1'b0;
      wake_cnt_q <= '0;
    end else if (need_wake) begin
      waking_q   <= 1'b1;
      wake_cnt_q <= WCW'(REF_WAKE_CYCLES - 1);
    end else if (waking_q) begin
      if (wake_cnt_q == '0) begin
        waking_q <= 1'b0;
      end else begin
        wake_cnt_q <= wake_cnt_q - WCW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_go_q <= 1'b0;
    end else begin
      conv_go_q <= (launch && !waking_q && !need_wake) || (waking_q && wake_cnt_q == '0);
    end
  end
  assign conv_go_o = conv_go_q;

  // Reference power: external modes keep it off, mode 10 holds it once woken
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vref_on_q <= 1'b0;
    end else if (ref_ext_o) begin
      vref_on_q <= 1'b0;
    end else if (launch) begin
      vref_on_q <= 1'b1;
    end else if (scan_done_i && vref_mode_o == RF_INT_AUTO) begin
      vref_on_q <= 1'b0;
    end
  end
  assign vref_on_o = vref_on_q;

  // Set wins over the end-of-scan clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      awake_q <= 1'b0;
    end else if (launch) begin
      awake_q <= 1'b1;
    end else if (scan_done_i) begin
      awake_q <= 1'b0;
    end
  end
  assign core_awake_o = awake_q;

  // Result formatting
  assign pair_bip  = result_diff_i && pair_flag(bi_q, result_pair_i) && !pair_flag(uni_q, result_pair_i);
  assign code_fmt  = pair_bip ? {~result_code_i[9], result_code_i[8:0]} : result_code_i;
  assign temp_diff = 14'({2'h0, temp_first_i}) - 14'({2'h0, temp_second_i}) - 14'({2'h0, TEMP_K_OFFSET});

  // One word in flight; the core must hold its result until ready
  assign tx_pend        = tx_req_q != ack_s;
  assign result_ready_o = !tx_pend;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_word_q <= 16'h0000;
      tx_req_q  <= 1'b0;
    end else if (!tx_pend && temp_valid_i) begin
      tx_word_q <= {`ADCSC_FRAME_LEAD, temp_diff[11:0]};
      tx_req_q  <= ~tx_req_q;
    end else if (!tx_pend && result_valid_i) begin
      tx_word_q <= {`ADCSC_FRAME_LEAD, code_fmt, result_sub_i};
      tx_req_q  <= ~tx_req_q;
    end
  end
  assign lif.tx_word = tx_word_q;
  assign lif.tx_req  = tx_req_q;

  // Checks
  property p_setup_write;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (cmd_stb && byte_val[7:6] == `ADCSC_SET_SEL_VAL) |=> (setup_q == $past(byte_val));
  endproperty
  a_setup_write: assert property (p_setup_write) else $error("setup byte not stored");

  property p_no_data;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (setup_wr && !byte_val[1]) |=> (dec_q == DEC_CMD && $stable(uni_q) && $stable(bi_q));
  endproperty
  a_no_data: assert property (p_no_data) else $error("pair register armed without select");

  property p_uni_store;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (data_stb && dec_q == DEC_UNI) |=> (uni_q == $past(byte_val) && $stable(bi_q));
  endproperty
  a_uni_store: assert property (p_uni_store) else $error("unipolar byte not stored");

  property p_bi_store;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (data_stb && dec_q == DEC_BI) |=> (bi_q == $past(byte_val) && $stable(uni_q));
  endproperty
  a_bi_store: assert property (p_bi_store) else $error("bipolar byte not stored");

  property p_serial_launch;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (conv_wr && clk_mode_o[1] && !waking_q && vref_mode_o != RF_INT_AUTO) |=> conv_go_o;
  endproperty
  a_serial_launch: assert property (p_serial_launch) else $error("command did not launch");

  property p_wake_delay;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      need_wake |=> (!conv_go_o && waking_q) [*8];
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("conversion before reference wake");

  property p_awake;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      conv_go_o |-> core_awake_o;
  endproperty
  a_awake: assert property (p_awake) else $error("conversion while shut down");

  property p_result_frame;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!tx_pend && result_valid_i && !temp_valid_i) |=>
        (tx_word_q[15:12] == 4'h0 && tx_word_q[1:0] == $past(result_sub_i) && tx_pend);
  endproperty
  a_result_frame: assert property (p_result_frame) else $error("result frame malformed");

  property p_uni_wins;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!tx_pend && result_valid_i && !temp_valid_i && pair_flag(uni_q, result_pair_i)) |=>
        (tx_word_q[11:2] == $past(result_code_i));
  endproperty
  a_uni_wins: assert property (p_uni_wins) else $error("unipolar pair not straight binary");
endmodule

// >>> verification/adcsc_host_model.sv
// Serial host model that drives command frames and reads back words
`timescale 1ns/1ps
module adcsc_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  // Clock stands low between frames; data shows the inverse once released
  task automatic frame(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
    rx = '0;
    #1.7;
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      din_o = tx[15-i];
      #40 sclk_o = 1'b1;
      if (i > 0) rx[16-i] = dout_i;
      #40 sclk_o = 1'b0;
    end
    #20 rx[16-nbits] = dout_i;
    cs_n_o = 1'b1;
    din_o  = ~din_o;
    #40;
  endtask
endmodule

// >>> verification/adcsc_top_test.sv
// Self-checking bench for the ADC setup and pair configuration block
`timescale 1ns/1ps
module adcsc_top_test;
  import adcsc_pkg::*;
  logic            clk_sys_i, rst_n_i, sclk, cs_n, din, dout, dout_f;
  logic            conv_start_n, scan_done, result_valid, temp_valid;
  logic            result_ready, conv_go, acq_hold, int_clk, sclk_clk, start_an, result_diff;
  logic [9:0]      result_code;
  logic            refneg_an, ref_ext, ref_diff, vref_on, awake;
  logic [2:0]      result_pair;
  logic [7:0]      p_uni, p_bi, p_diff, p_bip, conv_cmd;
  logic [15:0]     rx, mode_w;
  adcsc_clk_mode_t clk_mode;
  adcsc_ref_mode_t vref_mode;
  int              n_errors, samples_checked, go_cnt, go0;

  adcsc_host_model i_adcsc_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

  adcsc_top #(.REF_WAKE_CYCLES(50)) i_adcsc_top (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .dout_o(dout), .conv_start_n_i(conv_start_n), .scan_done_i(scan_done),
    .result_valid_i(result_valid), .result_code_i(result_code), .result_sub_i(2'h2),
    .result_diff_i(result_diff), .result_pair_i(result_pair), .temp_valid_i(temp_valid),
    .temp_first_i(12'hc00), .temp_second_i(12'h100), .result_ready_o(result_ready),
    .clk_mode_o(clk_mode), .vref_mode_o(vref_mode), .pair_uni_o(p_uni), .pair_bi_o(p_bi),
    .pair_diff_o(p_diff), .pair_bipolar_o(p_bip), .conv_cmd_o(conv_cmd), .conv_go_o(conv_go),
    .acq_hold_o(acq_hold), .int_conv_clk_o(int_clk), .sclk_conv_clk_o(sclk_clk),
    .start_pin_analog_o(start_an), .refneg_analog_o(refneg_an), .ref_ext_o(ref_ext),
    .ref_ext_diff_o(ref_diff), .vref_on_o(vref_on), .core_awake_o(awake)
  );

  assign mode_w = {4'h0, clk_mode, vref_mode, int_clk, sclk_clk, start_an, refneg_an, ref_ext, ref_diff,
                   vref_on, awake};

  function automatic logic [15:0] exp_mode(input logic [1:0] c, input logic [1:0] r, input logic von);
    return {4'h0, c, r, c != 2'h3, c == 2'h3, c[1], r != 2'h3, r[0], r == 2'h3, von, 1'b0};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input int nbits, input logic [15:0] tx);
    i_adcsc_host_model.frame(nbits, tx, rx);
    repeat (10) @(posedge clk_sys_i);
  endtask

  task automatic pin_pulse;
    @(posedge clk_sys_i);
    conv_start_n <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    chk({15'h0, acq_hold}, {15'h0, clk_mode == CK_INT_EXTACQ});
    conv_start_n <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
  endtask

  // Offers are held until taken; the word is read back in the second frame after it
  task automatic offer(input logic tv, input logic [2:0] pr, input logic [15:0] exp);
    @(posedge clk_sys_i);
    temp_valid   <= tv;
    result_valid <= ~tv;
    result_pair  <= pr;
    @(negedge clk_sys_i);
    while (result_ready !== 1'b1) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    temp_valid   <= 1'b0;
    result_valid <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    // The link needs two serial clocks to see the request, so a first frame primes it
    i_adcsc_host_model.frame(16, 16'h0000, rx);
    i_adcsc_host_model.frame(16, 16'h0000, rx);
    chk(rx, exp);
    repeat (5) @(posedge clk_sys_i);
  endtask

  task automatic final_report;
    $display("Errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) if (conv_go === 1'b1) go_cnt <= go_cnt + 1;
  // Output must not move while the host samples it
  always @(negedge sclk) #1 dout_f = dout;
  always @(posedge cs_n) dout_f = 1'b0;
  always @(posedge sclk) if (cs_n === 1'b0) chk({15'h0, dout}, {15'h0, dout_f});

  initial begin
    #100us;
    n_errors++;
    final_report();
  end

  initial begin
    {n_errors, samples_checked, go_cnt} = '0;
    dout_f = 1'b0;
    rst_n_i = 1'b0;
    conv_start_n = 1'b1;
    {scan_done, result_valid, temp_valid} = '0;
    result_pair = 3'h0;
    result_diff = 1'b1;
    result_code = 10'h2a5;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk(mode_w, exp_mode(2'h2, 2'h0, 1'b0));
    chk({p_uni, p_bi}, 16'h0000);
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      wr(8, {2'h1, 2'(m), 2'(m), 1'b0, 1'(m), 8'h00});
      chk(mode_w, exp_mode(2'(m), 2'(m), 1'b0));
      chk({p_uni, p_bi}, 16'h0000);
    end
    $display("mode test done");
    wr(16, 16'h42a5);
    chk({p_uni, p_bi}, 16'ha500);
    wr(16, 16'h433c);
    chk({p_uni, p_bi}, 16'ha53c);
    chk({p_diff, p_bip}, 16'hbd18);
    wr(8, 16'h4200);
    wr(8, 16'h5b00);
    chk({p_uni, p_bi}, 16'ha53c);
    chk(mode_w, exp_mode(2'h1, 2'h2, 1'b0));
    wr(16, 16'h400f);
    chk({p_uni, p_bi}, 16'ha53c);
    chk(mode_w, exp_mode(2'h0, 2'h0, 1'b0));
    $display("pair test done");
    wr(8, 16'h6000);
    go0 = go_cnt;
    wr(8, 16'h8600);
    chk(16'(go_cnt - go0), 16'h0000);
    repeat (30) @(posedge clk_sys_i);
    chk(16'(go_cnt - go0), 16'h0001);
    chk({6'h0, vref_on, awake, conv_cmd}, 16'h0386);
    @(posedge clk_sys_i);
    scan_done <= 1'b1;
    @(posedge clk_sys_i);
    scan_done <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk({14'h0, vref_on, awake}, 16'h0000);
    wr(8, 16'h6800);
    pin_pulse();
    chk(16'(go_cnt - go0), 16'h0001);
    wr(8, 16'h8600);
    chk(16'(go_cnt - go0), 16'h0002);
    wr(8, 16'h5800);
    pin_pulse();
    chk(16'(go_cnt - go0), 16'h0003);
    wr(8, 16'h5400);
    chk({15'h0, vref_on}, 16'h0000);
    wr(8, 16'h4400);
    pin_pulse();
    chk(16'(go_cnt - go0), 16'h0004);
    $display("launch test done");
    offer(1'b0, 3'h2, 16'h0a96);
    offer(1'b0, 3'h3, 16'h0296);
    offer(1'b1, 3'h0, 16'h0277);
    @(posedge clk_sys_i);
    result_diff <= 1'b0;
    result_code <= 10'h15a;
    offer(1'b0, 3'h3, 16'h056a);
    $display("result test done");
    final_report();
  end
endmodule
